// *** hdl/hdpc_top.sv ***
// How it works
// - Rate select 00 gives a 24 kHz upsample tick, 01 gives 48 kHz, else 12 kHz.
// - Gain writes are taken during playback only when the bypass bit is 1.
// - Output protection pulls the bridge low after output >= 124/128 rail lasts.
// - Output protection time is a 7-bit count of 1/3000 s units, reset zero.
// - Input protection pulls the bridge low after output >= level/128 rail lasts.
// - Input protection level is 7 bits resetting to 0x3F, enabled after reset.
// - Input protection time is an 8-bit count of 1/3000 s units, reset 0x32.
// - Battery adjust mode bit 0 is software adjust, 1 is hardware; reset 0.
// - The 3-bit reference code selects 3.3 to 5.5 V from a fixed table.
// - Hardware adjust output is reference times code over 128.
// - Hardware adjust saturates at the rail when ref*code/vbat exceeds 128.
// - Software adjust or boost gives rail times code over 128.
// - Detect ADC rate code resets to 01 and is passed to the converter.
// - Detect sampling runs only while the sampling control equals 01.
`timescale 1ns/10ps
`default_nettype none
module hdpc_top #(
  parameter int unsigned PROT_TICK_CYC = hdpc_pkg::PROT_TICK_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  input  wire hdpc_pkg::hdpc_reg_req_s reg_req_i,
  output var  logic [7:0]              reg_rdata_o,
  input  wire hdpc_pkg::hdpc_meas_s    meas_i,
  input  wire logic                    boost_active_i,
  input  wire logic                    playing_i,
  input  wire logic                    gain_wr_i,
  input  wire logic [7:0]              gain_i,
  input  wire logic                    wave_valid_i,
  input  wire logic signed [7:0]       wave_code_i,
  output var  logic                    ups_tick_o,
  output var  logic [7:0]              active_gain_o,
  output var  logic                    bridge_pull_low_o,
  output var  logic                    comp_valid_o,
  output var  logic                    comp_neg_o,
  output var  logic [15:0]             comp_mv_o,
  output var  logic [1:0]              detect_sample_rate_o,
  output var  logic                    detect_run_o
);

  typedef struct packed {
    logic [5:0][7:0]     regs;
    logic [7:0]          rdata;
    logic [11:0]         ups_cnt;
    logic                ups_tick;
    logic [13:0]         prot_cnt;
    hdpc_pkg::hdpc_mon_s out_mon;
    hdpc_pkg::hdpc_mon_s in_mon;
    logic                pull_low;
    logic [7:0]          gain;
    logic                comp_valid;
    logic                comp_neg;
    logic [15:0]         comp_mv;
  } hdpc_state_s;

  hdpc_state_s st_ff;
  hdpc_state_s nxt_st;

  function automatic logic [3:0] reg_decode(input logic [7:0] addr);
    case (addr)
      hdpc_pkg::ADDR_UPS:  reg_decode = {1'b1, hdpc_pkg::IDX_UPS};
      hdpc_pkg::ADDR_OUTP: reg_decode = {1'b1, hdpc_pkg::IDX_OUTP};
      hdpc_pkg::ADDR_INP:  reg_decode = {1'b1, hdpc_pkg::IDX_INP};
      hdpc_pkg::ADDR_INT:  reg_decode = {1'b1, hdpc_pkg::IDX_INT};
      hdpc_pkg::ADDR_BATT: reg_decode = {1'b1, hdpc_pkg::IDX_BATT};
      hdpc_pkg::ADDR_DET:  reg_decode = {1'b1, hdpc_pkg::IDX_DET};
      default:             reg_decode = 4'h0;
    endcase
  endfunction

  function automatic logic [11:0] ups_limit(input logic [1:0] sel);
    case (sel)
      hdpc_pkg::UPS_SEL_24K: ups_limit = 12'(hdpc_pkg::UPS_24K_CYC);
      hdpc_pkg::UPS_SEL_48K: ups_limit = 12'(hdpc_pkg::UPS_48K_CYC);
      default:               ups_limit = 12'(hdpc_pkg::UPS_12K_CYC);
    endcase
  endfunction

  // Shared by both monitors; only an unbroken excess reaches the trip state.
  function automatic hdpc_pkg::hdpc_mon_s mon_step(
    input hdpc_pkg::hdpc_mon_s cur,
    input logic                en,
    input logic                excess,
    input logic                tick,
    input logic [7:0]          dur
  );
    hdpc_pkg::hdpc_mon_s n;
    logic [8:0]          inc;
    n   = cur;
    inc = {1'b0, cur.cnt} + 9'h001;
    if (!en || !excess)
    begin
      n.st  = hdpc_pkg::MON_IDLE;
      n.cnt = 8'h00;
    end
    else
    begin
      case (cur.st)
        hdpc_pkg::MON_IDLE:
        begin
          n.st  = (dur == 8'h00) ? hdpc_pkg::MON_TRIP : hdpc_pkg::MON_COUNT;
          n.cnt = 8'h00;
        end
        hdpc_pkg::MON_COUNT:
        begin
          // A duration cut below the count already reached trips at once.
          if (cur.cnt >= dur)
          begin
            n.st = hdpc_pkg::MON_TRIP;
          end
          else if (tick)
          begin
            n.cnt = inc[7:0];
            if (inc >= {1'b0, dur})
            begin
              n.st = hdpc_pkg::MON_TRIP;
            end
          end
        end
        hdpc_pkg::MON_TRIP:
        begin
          n = cur;
        end
        default:
        begin
          n.st  = hdpc_pkg::MON_IDLE;
          n.cnt = 8'h00;
        end
      endcase
    end
    mon_step = n;
  endfunction

  logic [3:0]  wr_dec;
  logic [3:0]  rd_dec;
  logic [7:0]  ups_reg;
  logic [7:0]  outp_reg;
  logic [7:0]  inp_reg;
  logic [7:0]  det_reg;
  logic        hw_adj;
  logic        prot_tick;
  logic        out_excess;
  logic        in_excess;
  logic [22:0] out_x128;
  logic [7:0]  wave_mag;
  logic [15:0] vref_mv;
  logic [23:0] ref_prod;
  logic [23:0] rail_prod;
  logic [23:0] vbat_x128;

  always_comb
  begin
    wr_dec    = reg_decode(reg_req_i.addr);
    rd_dec    = wr_dec;
    ups_reg   = st_ff.regs[hdpc_pkg::IDX_UPS];
    outp_reg  = st_ff.regs[hdpc_pkg::IDX_OUTP];
    inp_reg   = st_ff.regs[hdpc_pkg::IDX_INP];
    det_reg   = st_ff.regs[hdpc_pkg::IDX_DET];
    hw_adj    = st_ff.regs[hdpc_pkg::IDX_BATT][hdpc_pkg::BATT_HW_BIT];
    prot_tick = (st_ff.prot_cnt == 14'(PROT_TICK_CYC - 1));
    out_x128  = {meas_i.out_mv, 7'h00};
    // Thresholds are compared scaled by 128 so no division is needed.
    out_excess = out_x128 >=
      23'(meas_i.rail_mv) * 23'(hdpc_pkg::OUT_THR_NUM);
    in_excess  = out_x128 >= 23'(meas_i.rail_mv) * 23'(inp_reg[6:0]);
    wave_mag  = wave_code_i[7] ? 8'(-wave_code_i) : 8'(wave_code_i);
    vref_mv   = hdpc_pkg::VREF_MV[det_reg[hdpc_pkg::VREF_LSB +: 3]];
    ref_prod  = vref_mv * wave_mag;
    rail_prod = meas_i.rail_mv * wave_mag;
    vbat_x128 = {1'b0, meas_i.vbat_mv, 7'h00};
  end

  always_comb
  begin
    nxt_st = st_ff;
    if (reg_req_i.wr && wr_dec[3])
    begin
      nxt_st.regs[wr_dec[2:0]] = reg_req_i.wdata;
    end
    if (reg_req_i.rd)
    begin
      nxt_st.rdata = rd_dec[3] ? st_ff.regs[rd_dec[2:0]] : 8'h00;
    end
    nxt_st.ups_tick = 1'b0;
    if (st_ff.ups_cnt >= ups_limit(ups_reg[hdpc_pkg::UPS_RATE_LSB +: 2]) - 12'h001)
    begin
      nxt_st.ups_cnt  = 12'h000;
      nxt_st.ups_tick = 1'b1;
    end
    else
    begin
      nxt_st.ups_cnt = st_ff.ups_cnt + 12'h001;
    end
    nxt_st.prot_cnt = prot_tick ? 14'h0000 : st_ff.prot_cnt + 14'h0001;
    nxt_st.out_mon = mon_step(st_ff.out_mon, outp_reg[hdpc_pkg::PROT_EN_BIT],
      out_excess, prot_tick, {1'b0, outp_reg[6:0]});
    nxt_st.in_mon = mon_step(st_ff.in_mon, inp_reg[hdpc_pkg::PROT_EN_BIT],
      in_excess, prot_tick, st_ff.regs[hdpc_pkg::IDX_INT]);
    nxt_st.pull_low = (nxt_st.out_mon.st == hdpc_pkg::MON_TRIP) ||
      (nxt_st.in_mon.st == hdpc_pkg::MON_TRIP);
    if (gain_wr_i && (!playing_i || ups_reg[hdpc_pkg::GAIN_BYP_BIT]))
    begin
      nxt_st.gain = gain_i;
    end
    nxt_st.comp_valid = wave_valid_i;
    if (wave_valid_i)
    begin
      nxt_st.comp_neg = wave_code_i[7];
      if (!hw_adj || boost_active_i)
      begin
        nxt_st.comp_mv = rail_prod[22:7];
      end
      else if (ref_prod > vbat_x128)
      begin
        nxt_st.comp_mv = meas_i.rail_mv;
      end
      else
      begin
        nxt_st.comp_mv = ref_prod[22:7];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      st_ff <= '0;
      st_ff.regs[hdpc_pkg::IDX_UPS]  <= hdpc_pkg::RST_UPS;
      st_ff.regs[hdpc_pkg::IDX_OUTP] <= hdpc_pkg::RST_OUTP;
      st_ff.regs[hdpc_pkg::IDX_INP]  <= hdpc_pkg::RST_INP;
      st_ff.regs[hdpc_pkg::IDX_INT]  <= hdpc_pkg::RST_INT;
      st_ff.regs[hdpc_pkg::IDX_BATT] <= hdpc_pkg::RST_BATT;
      st_ff.regs[hdpc_pkg::IDX_DET]  <= hdpc_pkg::RST_DET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  logic [1:0] nxt_det_rate;
  logic       nxt_det_run;
  logic [1:0] det_rate_ff;
  logic       det_run_ff;

  always_comb
  begin
    nxt_det_rate = det_reg[hdpc_pkg::DETECT_SAMPLE_RATE_LSB +: 2];
    nxt_det_run  = det_reg[hdpc_pkg::DET_LSB +: 2] == hdpc_pkg::DET_RUN_CODE;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      det_rate_ff <= hdpc_pkg::RST_DET[hdpc_pkg::DETECT_SAMPLE_RATE_LSB +: 2];
      det_run_ff  <= 1'b0;
    end
    else
    begin
      det_rate_ff <= nxt_det_rate;
      det_run_ff  <= nxt_det_run;
    end
  end

  assign reg_rdata_o          = st_ff.rdata;
  assign ups_tick_o           = st_ff.ups_tick;
  assign active_gain_o        = st_ff.gain;
  assign bridge_pull_low_o    = st_ff.pull_low;
  assign comp_valid_o         = st_ff.comp_valid;
  assign comp_neg_o           = st_ff.comp_neg;
  assign comp_mv_o            = st_ff.comp_mv;
  assign detect_sample_rate_o = det_rate_ff;
  assign detect_run_o         = det_run_ff;

  // Helper: cycles since the last tick, and whether the upsample register changed meanwhile.
  logic [11:0] gap_ff;
  logic        sel_moved_ff;
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || ups_tick_o)
    begin
      gap_ff       <= 12'h001;
      sel_moved_ff <= !resetn_i;
    end
    else
    begin
      gap_ff       <= gap_ff + 12'h001;
      sel_moved_ff <= sel_moved_ff || !$stable(ups_reg);
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  chk_ups_period: assert property (
    $rose(ups_tick_o) && !sel_moved_ff && !$stable(gap_ff) |->
      gap_ff == ups_limit($past(ups_reg[hdpc_pkg::UPS_RATE_LSB +: 2])))
    else $error("upsample tick spacing does not match rate select");

  chk_gain_hold: assert property (
    playing_i && !ups_reg[hdpc_pkg::GAIN_BYP_BIT] |=> $stable(active_gain_o))
    else $error("gain changed during playback while locked");

  chk_gain_take: assert property (
    gain_wr_i && ups_reg[hdpc_pkg::GAIN_BYP_BIT] |=>
      active_gain_o == $past(gain_i))
    else $error("gain write lost while bypass set");

  chk_out_immediate: assert property (
    outp_reg == 8'h80 && out_excess |=> bridge_pull_low_o)
    else $error("output protection with zero time did not pull low");

  chk_in_duration: assert property (
    $rose(st_ff.in_mon.st == hdpc_pkg::MON_TRIP) |->
      st_ff.in_mon.cnt >= $past(st_ff.regs[hdpc_pkg::IDX_INT]))
    else $error("input protection tripped before its time");

  chk_restart_clear: assert property (
    !(out_excess && outp_reg[7]) && !(in_excess && inp_reg[7]) |=>
      !bridge_pull_low_o && st_ff.in_mon.cnt == 8'h00)
    else $error("protection held after the excess ended");

  chk_hw_scale: assert property (
    wave_valid_i && hw_adj && !boost_active_i && ref_prod <= vbat_x128 |=>
      comp_valid_o && comp_mv_o == $past(ref_prod[22:7]))
    else $error("hardware adjust output wrong");

  chk_hw_saturate: assert property (
    wave_valid_i && hw_adj && !boost_active_i && ref_prod > vbat_x128 |=>
      comp_mv_o == $past(meas_i.rail_mv))
    else $error("hardware adjust did not saturate at rail");

  chk_sw_scale: assert property (
    wave_valid_i && (!hw_adj || boost_active_i) |=>
      comp_mv_o == $past(rail_prod[22:7]) && comp_neg_o == $past(wave_code_i[7]))
    else $error("software adjust output wrong");

  chk_det_control: assert property (
    ##1 detect_run_o == ($past(det_reg[1:0]) == hdpc_pkg::DET_RUN_CODE) &&
      detect_sample_rate_o == $past(det_reg[3:2]))
    else $error("detect control does not follow register");

  chk_rd_unmapped: assert property (
    reg_req_i.rd && !rd_dec[3] |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");

  cov_out_trip: cover property ($rose(st_ff.out_mon.st == hdpc_pkg::MON_TRIP));
  cov_in_trip: cover property ($rose(st_ff.in_mon.st == hdpc_pkg::MON_TRIP));
  cov_saturate: cover property (wave_valid_i && hw_adj && ref_prod > vbat_x128);

endmodule
`default_nettype wire

// *** hdl/hdpc_pkg.sv ***
package hdpc_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned UPS_24K_HZ    = 24_000;
  localparam int unsigned UPS_48K_HZ    = 48_000;
  localparam int unsigned UPS_12K_HZ    = 12_000;
  localparam int unsigned UPS_24K_CYC   = CLK_HZ / UPS_24K_HZ;
  localparam int unsigned UPS_48K_CYC   = CLK_HZ / UPS_48K_HZ;
  localparam int unsigned UPS_12K_CYC   = CLK_HZ / UPS_12K_HZ;
  localparam int unsigned PROT_UNIT_HZ  = 3_000;
  localparam int unsigned PROT_TICK_CYC = CLK_HZ / PROT_UNIT_HZ;

  localparam logic [7:0] ADDR_UPS  = 8'h46;
  localparam logic [7:0] ADDR_OUTP = 8'h48;
  localparam logic [7:0] ADDR_INP  = 8'h4A;
  localparam logic [7:0] ADDR_INT  = 8'h4B;
  localparam logic [7:0] ADDR_BATT = 8'h4C;
  localparam logic [7:0] ADDR_DET  = 8'h4D;

  localparam logic [2:0] IDX_UPS  = 3'h0;
  localparam logic [2:0] IDX_OUTP = 3'h1;
  localparam logic [2:0] IDX_INP  = 3'h2;
  localparam logic [2:0] IDX_INT  = 3'h3;
  localparam logic [2:0] IDX_BATT = 3'h4;
  localparam logic [2:0] IDX_DET  = 3'h5;

  localparam logic [7:0] RST_UPS  = 8'h08;
  localparam logic [7:0] RST_OUTP = 8'h00;
  localparam logic [7:0] RST_INP  = 8'hBF;
  localparam logic [7:0] RST_INT  = 8'h32;
  localparam logic [7:0] RST_BATT = 8'h00;
  localparam logic [7:0] RST_DET  = 8'h24;

  localparam int unsigned UPS_RATE_LSB = 5;
  localparam int unsigned GAIN_BYP_BIT = 0;
  localparam int unsigned PROT_EN_BIT  = 7;
  localparam int unsigned BATT_HW_BIT  = 6;
  localparam int unsigned VREF_LSB     = 4;
  localparam int unsigned DETECT_SAMPLE_RATE_LSB   = 2;
  localparam int unsigned DET_LSB      = 0;

  localparam logic [1:0]  UPS_SEL_24K  = 2'h0;
  localparam logic [1:0]  UPS_SEL_48K  = 2'h1;
  localparam logic [1:0]  DET_RUN_CODE = 2'h1;
  localparam logic [6:0]  OUT_THR_NUM  = 7'h7C;
  localparam int unsigned SCALE_SHIFT  = 7;

  // Hardware-adjust reference voltages in millivolts, code 7 down to 0.
  localparam logic [7:0][15:0] VREF_MV = {16'h157C, 16'h1388, 16'h12C0,
    16'h1194, 16'h1068, 16'h0FA0, 16'h0E10, 16'h0CE4};

  typedef enum logic [1:0] {MON_IDLE, MON_COUNT, MON_TRIP} hdpc_mon_e;

  typedef struct packed {
    hdpc_mon_e  st;
    logic [7:0] cnt;
  } hdpc_mon_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hdpc_reg_req_s;

  typedef struct packed {
    logic [15:0] out_mv;
    logic [15:0] rail_mv;
    logic [15:0] vbat_mv;
  } hdpc_meas_s;

endpackage

// *** testbench/hdpc_lra_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module hdpc_lra_model (
  input  wire logic                 pull_low_i,
  input  wire logic [15:0]          drive_mv_i,
  input  wire logic [15:0]          rail_mv_i,
  input  wire logic [15:0]          vbat_mv_i,
  output var  hdpc_pkg::hdpc_meas_s meas_o
);
  // A bridge pulled low shows no voltage, so a trip removes its own cause.
  always_comb
  begin
    meas_o.out_mv  = pull_low_i ? 16'h0000 : drive_mv_i;
    meas_o.rail_mv = rail_mv_i;
    meas_o.vbat_mv = vbat_mv_i;
  end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int T = 20;
  logic                    clk_i    = 1'h0;
  logic                    resetn_i = 1'h0;
  hdpc_pkg::hdpc_reg_req_s req      = '0;
  hdpc_pkg::hdpc_meas_s    meas;
  logic [7:0]              rdata, again, d;
  logic [7:0]              gain     = 8'h00;
  logic                    bst = 1'h0, play = 1'h0, gwr = 1'h0, wv = 1'h0;
  logic                    pl, tick, cv, cn, drun;
  logic signed [7:0]       wc       = 8'sh00;
  logic signed [7:0]       c;
  logic [15:0]             drive    = 16'h0000;
  logic [15:0]             rail     = 16'h1F40;
  logic [15:0]             vbat     = 16'h0FA0;
  logic [15:0]             cmv;
  logic [1:0]              dsr;
  logic [31:0]             rnd      = 32'hB85FBCEF;
  logic [7:0]              ra [6] = '{8'h46, 8'h48, 8'h4A, 8'h4B, 8'h4C,
                                      8'h4D};
  logic [7:0]              rv [6] = '{8'h08, 8'h00, 8'hBF, 8'h32, 8'h00,
                                      8'h24};
  logic [6:0]              dl [4] = '{7'h00, 7'h01, 7'h05, 7'h7F};
  int                      err_total = 0, n_tests = 0, cyc = 0, n, lo;

  always #12.5 clk_i = ~clk_i;

  hdpc_lra_model lra (.pull_low_i(pl), .drive_mv_i(drive), .rail_mv_i(rail),
    .vbat_mv_i(vbat), .meas_o(meas));

  hdpc_top #(.PROT_TICK_CYC(T)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .meas_i(meas),
    .boost_active_i(bst), .playing_i(play), .gain_wr_i(gwr), .gain_i(gain),
    .wave_valid_i(wv), .wave_code_i(wc), .ups_tick_o(tick),
    .active_gain_o(again), .bridge_pull_low_o(pl), .comp_valid_o(cv),
    .comp_neg_o(cn), .comp_mv_o(cmv), .detect_sample_rate_o(dsr),
    .detect_run_o(drun));

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [16:0] ex(logic hw, logic bs, logic [2:0] rs,
    logic signed [7:0] k, logic [15:0] rl, logic [15:0] vb);
    logic [15:0] tab [8] = '{16'h0CE4, 16'h0E10, 16'h0FA0, 16'h1068,
                             16'h1194, 16'h12C0, 16'h1388, 16'h157C};
    int m, p, v;
    m = k < 0 ? -int'(k) : int'(k);
    p = tab[rs] * m;
    if (hw && !bs)
      v = p > vb * 128 ? int'(rl) : p >> 7;
    else
      v = (rl * m) >> 7;
    return {k < 0, v[15:0]};
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    req <= '{1'h1, 1'h0, a, v};
    @(posedge clk_i);
    req.wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    req <= '{1'h0, 1'h1, a, 8'h00};
    @(posedge clk_i);
    req.rd <= 1'h0;
    #1 v = rdata;
  endtask

  task automatic gap;
    n = 0;
    do
    begin
      @(posedge clk_i);
      #1 n++;
    end
    while (n < 4000 && tick !== 1'h1);
  endtask

  task automatic hold(input logic [15:0] mv, input int k);
    n = 0;
    @(posedge clk_i);
    drive <= mv;
    repeat (k)
    begin
      @(posedge clk_i);
      #1 n += (pl === 1'h1);
    end
  endtask

  task automatic trip(input logic [15:0] mv);
    n = 0;
    @(posedge clk_i);
    drive <= mv;
    do
    begin
      @(posedge clk_i);
      #1 n++;
    end
    while (n < 3000 && pl !== 1'h1);
  endtask

  task automatic gtry(input logic p, input logic [7:0] v);
    @(posedge clk_i);
    play <= p;
    gwr  <= 1'h1;
    gain <= v;
    @(posedge clk_i);
    gwr <= 1'h0;
    #1;
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      close_out();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'h1;
    #1 chk({dsr, drun, pl, again}, {2'h1, 10'h000});
    foreach (ra[i])
    begin
      rd(ra[i], d);
      chk(d, rv[i]);
    end
    hold(16'h0F61, 1100);
    chk(n, 0);
    trip(16'h0F62);
    chk(n >= 49 * T + 1 && n <= 50 * T + 3, 1);
    hold(16'h0000, 4);
    foreach (ra[i])
    begin
      repeat (32) rnd = lfsr(rnd);
      wr(ra[i], rnd[7:0]);
      rd(ra[i], d);
      chk(d, rnd[7:0]);
    end
    wr(8'h47, 8'hA5);
    rd(8'h47, d);
    chk(d, 8'h00);
    // The first gap after a rate change may be short, so the third counts.
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h46, {1'h0, s[1:0], 5'h08});
      repeat (3) gap();
      chk(n, s == 0 ? 1666 : s == 1 ? 833 : 3333);
    end
    wr(8'h46, 8'h08);
    gtry(1'h0, 8'h5A);
    chk(again, 8'h5A);
    gtry(1'h1, 8'hC3);
    chk(again, 8'h5A);
    wr(8'h46, 8'h09);
    gtry(1'h1, 8'h3C);
    chk(again, 8'h3C);
    wr(8'h4A, 8'h3F);
    foreach (dl[i])
    begin
      wr(8'h48, {1'h1, dl[i]});
      hold(16'h1E45, 300);
      chk(n, 0);
      trip(16'h1E46);
      lo = dl[i] == 0 ? 1 : (dl[i] - 1) * T + 1;
      chk(n >= lo && n <= dl[i] * T + 3, 1);
      hold(16'h0000, 4);
      chk(pl, 1'h0);
    end
    wr(8'h48, 8'h05);
    hold(16'h3E80, 300);
    chk(n, 0);
    wr(8'h48, 8'h85);
    hold(16'h1E46, 60);
    hold(16'h1E45, 1);
    trip(16'h1E46);
    chk(n >= 4 * T + 1 && n <= 5 * T + 3, 1);
    hold(16'h0000, 4);
    wr(8'h48, 8'h00);
    wr(8'h4A, 8'hC0);
    wr(8'h4B, 8'h03);
    hold(16'h0F9F, 300);
    chk(n, 0);
    trip(16'h0FA0);
    chk(n >= 2 * T + 1 && n <= 3 * T + 3, 1);
    hold(16'h0000, 4);
    wr(8'h4A, 8'h3F);
    for (int i = 0; i < 40; i++)
    begin
      repeat (32) rnd = lfsr(rnd);
      c = i == 0 ? 8'sh80 : i == 1 ? 8'sh7F : i == 2 ? 8'sh00 : rnd[7:0];
      wr(8'h4C, {1'h0, rnd[8], 6'h00});
      wr(8'h4D, {1'h0, rnd[14:12], 4'h0});
      rail <= 16'h1770 + {4'h0, rnd[27:16]};
      vbat <= 16'h0BB8 + {5'h00, rnd[31:21]};
      bst  <= rnd[9] & rnd[10];
      @(posedge clk_i);
      wv <= 1'h1;
      wc <= c;
      @(posedge clk_i);
      wv <= 1'h0;
      #1 chk({cv, cn, cmv}, {1'h1, ex(rnd[8], bst, rnd[14:12], c, rail,
        vbat)});
    end
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h4D, {4'h2, i[3:0]});
      @(posedge clk_i);
      #1 chk({dsr, drun}, {i[3:2], i[1:0] == 2'h1});
    end
    close_out();
  end
endmodule
`default_nettype wire
